// File: inc/adc_seq_pkg.sv
// Constants and types for the sample sequencer control block
//------------------------------------------------------------
//------------------------------------------------------------
package adc_seq_pkg;
    // Register offsets
    localparam logic [11:0] OFF_ENABLE    = 12'h000;
    localparam logic [11:0] OFF_RAW_IRQ   = 12'h004;
    localparam logic [11:0] OFF_IRQ_MASK  = 12'h008;
    localparam logic [11:0] OFF_IRQ_CLR   = 12'h00c;
    localparam logic [11:0] OFF_OVERFLOW  = 12'h010;
    localparam logic [11:0] OFF_TRIG_SEL  = 12'h014;
    localparam logic [11:0] OFF_UNDERFLOW = 12'h018;
    localparam logic [11:0] OFF_PRIORITY  = 12'h020;
    localparam logic [11:0] OFF_INITIATE  = 12'h028;
    localparam logic [11:0] OFF_AVERAGE   = 12'h030;
    localparam logic [11:0] OFF_SEQ_BASE  = 12'h040;
    localparam logic [11:0] OFF_LOOPBACK  = 12'h100;
    // Per-sequencer block: stride and sub-offsets
    localparam logic [11:0] SEQ_STRIDE    = 12'h020;
    localparam logic [4:0]  SUB_MUX       = 5'h00;
    localparam logic [4:0]  SUB_CTL       = 5'h04;
    localparam logic [4:0]  SUB_FIFO      = 5'h08;
    localparam logic [4:0]  SUB_FSTAT     = 5'h0c;
    // Reset values
    localparam logic [15:0] PRIORITY_RST  = 16'h3210;
    localparam logic [31:0] CTL3_RST      = 32'h0000_0002;
    // Control nibble field positions
    localparam int CTL_DIFF = 0;
    localparam int CTL_LAST = 1;
    localparam int CTL_IRQ  = 2;
    localparam int CTL_TEMP = 3;
    // Status field positions
    localparam int FST_TAIL  = 0;
    localparam int FST_HEAD  = 4;
    localparam int FST_EMPTY = 8;
    localparam int FST_FULL  = 12;
    // Trigger sources
    localparam logic [3:0] TRIG_PROC   = 4'h0;
    localparam logic [3:0] TRIG_ALWAYS = 4'hf;
    localparam int NUM_EVENTS = 8;
    // Averaging: exponent max 6 (64 samples)
    localparam logic [2:0] AVG_MAX = 3'h6;
    // Clocking: system rate and target ADC rate in kHz
    localparam int SYS_KHZ = 125000;
    localparam int ADC_KHZ = 16667;
    localparam int ADC_DIV = (SYS_KHZ + ADC_KHZ - 1) / ADC_KHZ;
    // Differential zero code
    localparam logic [9:0] DIFF_MID = 10'h1ff;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONV = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_STEP = 4'b1000
    } fsm_type;
endpackage

// File: core/adc_seq_ctrl.sv
// Sample sequencer control with APB registers, FIFOs and arbitration
`timescale 1ns/1ps
module adc_seq_ctrl
    import adc_seq_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Peripheral trigger events, one-cycle pulses
    input  wire logic [NUM_EVENTS-1:0] trigEvents,
    // Converter side
    output logic             convStart,
    output logic      [2:0]  convInput,
    output logic             convDiff,
    output logic             convTemp,
    input  wire logic        convDone,
    input  wire logic [9:0]  convResult,
    // Interrupt line
    output logic             irqOut
);

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    typedef struct packed {
        logic [3:0]       enable;
        logic [3:0]       rawIrq;
        logic [3:0]       irqMask;
        logic [3:0]       overflow;
        logic [3:0]       underflow;
        logic [15:0]      trigSel;
        logic [15:0]      prio;
        logic [2:0]       average;
        logic             loopback;
        logic [3:0]       pending;
        logic [3:0][31:0] muxReg;
        logic [3:0][31:0] ctlReg;
        logic [3:0][7:0][9:0] fifo;
        logic [3:0][3:0]  head;
        logic [3:0][3:0]  tail;
        logic [3:0][3:0]  count;
        fsm_type          fsm;
        logic [1:0]       active;
        logic [2:0]       step;
        logic [6:0]       avgCnt;
        logic [15:0]      accum;
        logic [3:0]       divCnt;
        logic             convStart;
        logic [31:0]      rdata;
        logic             ready;
    } state_type;

    state_type q, d;

    // Depth of a sequencer FIFO, also its step count
    function automatic logic [3:0] depthOf(input logic [1:0] s);
        case (s)
            2'd0:    depthOf = 4'd8;
            2'd3:    depthOf = 4'd1;
            default: depthOf = 4'd4;
        endcase
    endfunction

    // Sequencer index for a per-sequencer register address, or none
    function automatic logic [2:0] seqOf(input logic [11:0] a);
        if (a >= OFF_SEQ_BASE && a < OFF_SEQ_BASE + 4 * SEQ_STRIDE) begin
            seqOf = {1'b1, 2'((a - OFF_SEQ_BASE) >> 5)};
        end else begin
            seqOf = 3'b000;
        end
    endfunction

    //------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------
    logic       setupRd;
    logic       accessWr;
    logic [3:0] irqEvt;
    logic [3:0] ovfEvt;
    logic [3:0] unfEvt;
    logic [2:0] selSeq;
    logic [4:0] sub;
    logic [3:0] trigNow;
    logic [1:0] best;
    logic       found;
    logic [3:0] nib;
    logic [3:0] ctlNib;
    logic [9:0] sample;
    logic [15:0] avgOut;
    logic [3:0] pushSeq;
    logic [3:0] popSeq;
    logic [1:0] bestPri;

    always_comb begin
        d = q;
        d.convStart = 1'b0;
        d.ready = 1'b0;
        setupRd = psel && !penable && !pwrite;
        // Writes land at the access edge, where the master sees pready high
        accessWr = psel && penable && pwrite && q.ready;
        irqEvt = 4'h0;
        ovfEvt = 4'h0;
        unfEvt = 4'h0;
        selSeq = seqOf(paddr);
        sub = paddr[4:0];
        pushSeq = 4'h0;
        popSeq = 4'h0;
        trigNow = 4'h0;
        best = 2'd0;
        bestPri = 2'd3;
        found = 1'b0;
        avgOut = 16'h0;

        d.divCnt = (q.divCnt == 4'(ADC_DIV - 1)) ? 4'h0 : q.divCnt + 4'h1;

        // Answer each access one cycle after setup
        if (psel && !penable) begin
            d.ready = 1'b1;
        end

        for (int s = 0; s < 4; s++) begin
            case (q.trigSel[s*4 +: 4])
                TRIG_PROC:   trigNow[s] = 1'b0;
                TRIG_ALWAYS: trigNow[s] = 1'b1;
                default:     trigNow[s] = trigEvents[3'(q.trigSel[s*4 +: 4] - 4'h1)];
            endcase
            if (trigNow[s] && q.enable[s]) begin
                d.pending[s] = 1'b1;
            end
        end

        if (accessWr && paddr == OFF_INITIATE) begin
            for (int s = 0; s < 4; s++) begin
                if (pwdata[s] && q.trigSel[s*4 +: 4] == TRIG_PROC && q.enable[s]) begin
                    d.pending[s] = 1'b1;
                end
            end
        end

        // pick pending sequencer with lowest priority value
        for (int s = 0; s < 4; s++) begin
            if (q.pending[s] && q.enable[s] &&
                (!found || q.prio[s*4 +: 2] < bestPri)) begin
                found = 1'b1;
                best = 2'(s);
                bestPri = q.prio[s*4 +: 2];
            end
        end

        // Current step configuration
        nib = q.muxReg[q.active][q.step*4 +: 4];
        ctlNib = q.ctlReg[q.active][q.step*4 +: 4];
        // loopback replaces converter data with step and sequencer ids
        sample = q.loopback ? {5'h0, q.active, q.step} : convResult;

        case (q.fsm)
            ST_IDLE: begin
                if (found && q.divCnt == 4'h0) begin
                    d.active = best;
                    d.pending[best] = 1'b0;
                    d.step = 3'h0;
                    d.fsm = ST_CONV;
                end
            end
            ST_CONV: begin
                d.convStart = 1'b1;
                d.fsm = ST_WAIT;
            end
            ST_WAIT: begin
                if (!q.enable[q.active]) begin
                    d.fsm = ST_IDLE;
                    d.avgCnt = 7'h0;
                    d.accum = 16'h0;
                end else if (convDone || q.loopback) begin
                    d.accum = q.accum + {6'h0, sample};
                    if (q.avgCnt == 7'((1 << q.average) - 1)) begin
                        avgOut = d.accum >> q.average;
                        d.avgCnt = 7'h0;
                        d.accum = 16'h0;
                        d.fsm = ST_STEP;
                        pushSeq[q.active] = 1'b1;
                    end else begin
                        d.avgCnt = q.avgCnt + 7'h1;
                        d.fsm = ST_CONV;
                    end
                end
            end
            ST_STEP: begin
                if (ctlNib[CTL_IRQ]) begin
                    d.rawIrq[q.active] = 1'b1;
                    irqEvt[q.active] = 1'b1;
                end
                // end at marked last step or at maximum count
                if (ctlNib[CTL_LAST] || 4'(q.step) + 4'h1 >= depthOf(q.active)) begin
                    d.fsm = ST_IDLE;
                end else begin
                    d.step = q.step + 3'h1;
                    d.fsm = ST_CONV;
                end
            end
            default: d.fsm = ST_IDLE;
        endcase

        // write one clears; a new step interrupt set wins
        if (accessWr && paddr == OFF_IRQ_CLR) begin
            d.rawIrq = (q.rawIrq & ~pwdata[3:0]) | irqEvt;
        end

        if (setupRd && selSeq[2] && sub == SUB_FIFO) begin
            popSeq[selSeq[1:0]] = 1'b1;
        end

        // circular FIFOs with overflow and underflow flags
        for (int s = 0; s < 4; s++) begin
            if (pushSeq[s]) begin
                if (q.count[s] == depthOf(2'(s))) begin
                    d.overflow[s] = 1'b1;
                    ovfEvt[s] = 1'b1;
                end else begin
                    d.fifo[s][q.tail[s]] = avgOut[9:0];
                    d.tail[s] = (q.tail[s] + 4'h1 == depthOf(2'(s))) ? 4'h0 : q.tail[s] + 4'h1;
                    d.count[s] = d.count[s] + 4'h1;
                end
            end
            if (popSeq[s]) begin
                if (q.count[s] == 4'h0) begin
                    d.underflow[s] = 1'b1;
                    unfEvt[s] = 1'b1;
                end else begin
                    d.head[s] = (q.head[s] + 4'h1 == depthOf(2'(s))) ? 4'h0 : q.head[s] + 4'h1;
                    d.count[s] = d.count[s] - 4'h1;
                end
            end
        end

        // Register writes
        if (accessWr) begin
            case (paddr)
                OFF_ENABLE:    d.enable = pwdata[3:0];
                OFF_IRQ_MASK:  d.irqMask = pwdata[3:0];
                // flags raised in this very cycle survive the clear
                OFF_OVERFLOW:  d.overflow = (q.overflow & ~pwdata[3:0]) | ovfEvt;
                OFF_UNDERFLOW: d.underflow = (q.underflow & ~pwdata[3:0]) | unfEvt;
                OFF_TRIG_SEL:  d.trigSel = pwdata[15:0];
                OFF_PRIORITY:  d.prio = pwdata[15:0] & 16'h3333;
                // one averaging setting, capped at 64 samples
                OFF_AVERAGE:   d.average = (pwdata[2:0] > AVG_MAX) ? AVG_MAX : pwdata[2:0];
                OFF_LOOPBACK:  d.loopback = pwdata[0];
                default: begin
                    // step nibbles writable at any time
                    if (selSeq[2] && sub == SUB_MUX) begin
                        d.muxReg[selSeq[1:0]] = pwdata;
                    end else if (selSeq[2] && sub == SUB_CTL) begin
                        d.ctlReg[selSeq[1:0]] = pwdata;
                    end
                end
            endcase
        end

        // Register reads captured at setup
        if (setupRd) begin
            d.rdata = 32'h0;
            case (paddr)
                OFF_ENABLE:    d.rdata[3:0] = q.enable;
                OFF_RAW_IRQ:   d.rdata[3:0] = q.rawIrq;
                OFF_IRQ_MASK:  d.rdata[3:0] = q.irqMask;
                OFF_IRQ_CLR:   d.rdata[3:0] = q.rawIrq & q.irqMask;
                OFF_OVERFLOW:  d.rdata[3:0] = q.overflow;
                OFF_UNDERFLOW: d.rdata[3:0] = q.underflow;
                OFF_TRIG_SEL:  d.rdata[15:0] = q.trigSel;
                OFF_PRIORITY:  d.rdata[15:0] = q.prio;
                OFF_AVERAGE:   d.rdata[2:0] = q.average;
                OFF_LOOPBACK:  d.rdata[0] = q.loopback;
                default: begin
                    if (selSeq[2]) begin
                        case (sub)
                            SUB_MUX:  d.rdata = q.muxReg[selSeq[1:0]];
                            SUB_CTL:  d.rdata = q.ctlReg[selSeq[1:0]];
                            SUB_FIFO: d.rdata[9:0] = q.fifo[selSeq[1:0]][q.head[selSeq[1:0]]];
                            SUB_FSTAT: begin
                                d.rdata[FST_TAIL +: 4] = q.tail[selSeq[1:0]];
                                d.rdata[FST_HEAD +: 4] = q.head[selSeq[1:0]];
                                d.rdata[FST_EMPTY] = (q.count[selSeq[1:0]] == 4'h0);
                                d.rdata[FST_FULL] = (q.count[selSeq[1:0]]
                                                     == depthOf(selSeq[1:0]));
                            end
                            default: d.rdata = 32'h0;
                        endcase
                    end
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
            q.prio <= PRIORITY_RST;
            q.ctlReg[3] <= CTL3_RST;
            q.fsm <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    // differential pair k drives inputs 2k and 2k+1, even input first
    assign convInput = ctlNib[CTL_DIFF] ? {nib[1:0], 1'b0} : nib[2:0];
    assign convDiff  = ctlNib[CTL_DIFF];
    assign convTemp  = ctlNib[CTL_TEMP];
    assign convStart = q.convStart && !q.loopback;
    assign prdata    = q.rdata;
    assign pready    = q.ready;
    assign pslverr   = 1'b0;
    assign irqOut    = |(q.rawIrq & q.irqMask);

endmodule

// File: tb/adc_seq_ctrl_sva.sv
// Port-level assertions for the sequencer control block
`timescale 1ns/1ps
module adc_seq_ctrl_sva
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  srst,
    // APB slave
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Triggers, converter and interrupt
    input wire logic [NUM_EVENTS-1:0] trigEvents,
    input wire logic                  convStart,
    input wire logic [2:0]            convInput,
    input wire logic                  convDiff,
    input wire logic                  convTemp,
    input wire logic                  convDone,
    input wire logic [9:0]            convResult,
    input wire logic                  irqOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_no_error: assert property (!pslverr)
        else $error("pslverr raised");
    a_start_pulse: assert property (convStart |=> !convStart)
        else $error("convStart longer than one cycle");
    a_select_held: assert property (convStart |=> $stable({convInput, convDiff, convTemp}) [*2])
        else $error("step selection moved during conversion");
    a_irq_clear: assert property ($fell(irqOut) |-> $past(psel && pwrite) || $past(psel && pwrite, 2))
        else $error("irqOut fell without a write");
    a_unmapped_zero: assert property (pready && !pwrite && paddr > OFF_LOOPBACK |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_fifo_upper: assert property (pready && !pwrite && paddr >= OFF_SEQ_BASE && paddr < OFF_LOOPBACK
        && paddr[4:0] == SUB_FIFO |-> prdata[31:10] == 22'h0)
        else $error("fifo word upper bits set");
    a_reset_quiet: assert property ($fell(srst) |-> !irqOut && !convStart)
        else $error("outputs active after reset");
    a_diff_even: assert property (convStart && convDiff |-> !convInput[0])
        else $error("differential step not on an even input");

    // Main scenarios
    c_conv: cover property (convStart);
    c_irq_clear: cover property ($fell(irqOut));
    c_fifo_read: cover property (pready && !pwrite && paddr[4:0] == SUB_FIFO);
    c_diff: cover property (convStart && convDiff);
endmodule

// File: tb/conv_model.sv
// Behavioural converter on the far side of the sequencer control
`timescale 1ns/1ps
module conv_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Conversion request and answer
    input  wire logic       convStart,
    input  wire logic [2:0] convInput,
    input  wire logic       convTemp,
    output logic            convDone,
    output logic [9:0]      convResult
);
    logic [6:0] cnt;
    logic [2:0] sel;
    int         waitQ;
    initial convDone = 1'b0;
    initial convResult = 10'h000;
    // Result carries the input and a running count, so order errors show
    // A temperature step reads as input code 7
    always @(posedge clk) begin
        if (srst) begin
            cnt <= 7'h00;
            waitQ <= 0;
            convDone <= 1'b0;
        end else if (waitQ == 1) begin
            waitQ <= 0;
            convDone <= 1'b1;
            convResult <= {sel, cnt};
            cnt <= cnt + 7'h01;
        end else begin
            convDone <= 1'b0;
            // Outside the done pulse the result bus shows garbage
            convResult <= ~convResult;
            if (waitQ != 0) begin
                waitQ <= waitQ - 1;
            end else if (convStart) begin
                sel <= convTemp ? 3'h7 : convInput;
                waitQ <= $urandom_range(5, 2);
            end
        end
    end
endmodule

// File: tb/test_adc_seq_ctrl.sv
// Self-checking bench for the sequencer control block
`timescale 1ns/1ps
module test_adc_seq_ctrl;
    import adc_seq_pkg::*;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, mux;
    logic pready, pslverr, convStart, convDiff, convTemp, convDone, irqOut;
    logic [7:0] trigEvents = 8'h00;
    logic [2:0] convInput;
    logic [9:0] convResult;
    logic [6:0] expCnt;
    int mismatches = 0, samples_checked = 0, n, k, e, tot = 0;
    logic [11:0] ra [14] = '{OFF_ENABLE, OFF_RAW_IRQ, OFF_IRQ_MASK, OFF_IRQ_CLR, OFF_OVERFLOW,
        OFF_TRIG_SEL, OFF_UNDERFLOW, OFF_PRIORITY, OFF_AVERAGE, 12'h0a4, 12'h04c, OFF_LOOPBACK,
        12'h0fc, 12'h104};
    logic [31:0] rv [14] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h3210, 32'h0,
        CTL3_RST, 32'h100, 32'h0, 32'h0, 32'h0};
    always #4 clk = ~clk;
    adc_seq_ctrl DUT (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .trigEvents, .convStart, .convInput, .convDiff, .convTemp, .convDone,
        .convResult, .irqOut);
    conv_model PEER (.clk, .srst, .convStart, .convInput, .convTemp, .convDone, .convResult);

    // APB master: request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Look mid-cycle, clear of the edge that moves pready and prdata
        @(negedge clk);
        while (pready !== 1'b1) @(negedge clk);
        rd = prdata;
        // The edge at which pready is sampled high ends the transfer
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // Bounded poll until the masked bits reach a value
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        repeat (300) begin
            apb(1'b0, a, 32'h0);
            if ((rd & m) === v) break;
        end
    endtask
    function automatic logic [11:0] sa(input int s, input logic [4:0] sub);
        return OFF_SEQ_BASE + SEQ_STRIDE * 12'(s) + {7'h00, sub};
    endfunction
    // Pop one entry and compare with the next expected conversion
    task automatic pop(input int s, input logic [2:0] sel);
        apb(1'b0, sa(s, SUB_FIFO), 32'h0);
        chk("fifo", {22'h0, sel, expCnt}, rd);
        expCnt++;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog sized well beyond the expected run
    initial begin
        #400000;
        mismatches++;
        final_report();
    end
    // Main sequence
    initial begin
        void'($urandom(32'h18030ab7));
        expCnt = 7'h00;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 14; i++) rchk("reset", ra[i], rv[i]);
        $display("reset values done");
        for (int it = 0; it < 3; it++) begin
            n = (it == 0) ? 8 : (it == 1) ? 1 : $urandom_range(7, 2);
            tot += n;
            mux = $urandom & 32'h77777777;
            apb(1'b1, sa(0, SUB_MUX), mux);
            apb(1'b1, sa(0, SUB_CTL), 32'h6 << (4 * (n - 1)));
            apb(1'b1, OFF_ENABLE, 32'h1);
            apb(1'b1, OFF_INITIATE, 32'h1);
            poll(OFF_RAW_IRQ, 32'h1, 32'h1);
            chk("raw", 32'h1, rd);
            apb(1'b0, sa(0, SUB_FSTAT), 32'h0);
            chk("full", {31'h0, n == 8}, {31'h0, rd[FST_FULL]});
            for (int j = 0; j < n; j++) pop(0, mux[4 * j +: 3]);
            apb(1'b0, sa(0, SUB_FSTAT), 32'h0);
            chk("empty", 32'h1, {31'h0, rd[FST_EMPTY]});
            apb(1'b0, sa(0, SUB_FIFO), 32'h0);
            rchk("under", OFF_UNDERFLOW, 32'h1);
            apb(1'b1, OFF_UNDERFLOW, 32'h1);
            rchk("underclr", OFF_UNDERFLOW, 32'h0);
            apb(1'b1, OFF_IRQ_MASK, 32'h1);
            rchk("masked", OFF_IRQ_CLR, 32'h1);
            chk("irq", 32'h1, {31'h0, irqOut});
            apb(1'b1, OFF_IRQ_CLR, 32'h0);
            @(negedge clk);
            chk("irqkeep", 32'h1, {31'h0, irqOut});
            apb(1'b1, OFF_IRQ_CLR, 32'h1);
            @(negedge clk);
            chk("irqclr", 32'h0, {31'h0, irqOut});
            rchk("rawclr", OFF_RAW_IRQ, 32'h0);
            apb(1'b1, OFF_IRQ_MASK, 32'h0);
            apb(1'b1, OFF_ENABLE, 32'h0);
        end
        apb(1'b1, OFF_INITIATE, 32'h1);
        repeat (60) @(posedge clk);
        rchk("idle", sa(0, SUB_FSTAT), 32'h100 | {24'h0, 4'(tot % 8), 4'(tot % 8)});
        $display("sequencer zero done");
        // Peripheral event trigger on sequencer one
        // avoid starvation
        k = $urandom_range(8, 1);
        mux = $urandom & 32'h7;
        apb(1'b1, OFF_TRIG_SEL, 32'(k) << 4);
        apb(1'b1, sa(1, SUB_MUX), mux);
        apb(1'b1, sa(1, SUB_CTL), 32'h2);
        apb(1'b1, OFF_ENABLE, 32'h2);
        trigEvents <= 8'h01 << (k - 1);
        @(posedge clk);
        trigEvents <= 8'h00;
        poll(sa(1, SUB_FSTAT), 32'h100, 32'h0);
        pop(1, mux[2:0]);
        apb(1'b1, OFF_ENABLE, 32'h0);
        $display("event trigger done");
        apb(1'b1, OFF_PRIORITY, 32'h3021);
        apb(1'b1, sa(0, SUB_MUX), 32'h3);
        apb(1'b1, sa(2, SUB_MUX), 32'h6);
        apb(1'b1, sa(0, SUB_CTL), 32'h2);
        apb(1'b1, sa(2, SUB_CTL), 32'h2);
        apb(1'b1, OFF_ENABLE, 32'h5);
        apb(1'b1, OFF_INITIATE, 32'h5);
        poll(sa(0, SUB_FSTAT), 32'h100, 32'h0);
        pop(2, 3'h6);
        pop(0, 3'h3);
        $display("priority done");
        apb(1'b1, OFF_ENABLE, 32'h8);
        apb(1'b1, OFF_INITIATE, 32'h8);
        poll(sa(3, SUB_FSTAT), 32'h100, 32'h0);
        apb(1'b1, OFF_INITIATE, 32'h8);
        poll(OFF_OVERFLOW, 32'h8, 32'h8);
        chk("over", 32'h8, rd);
        apb(1'b1, OFF_OVERFLOW, 32'h8);
        rchk("overclr", OFF_OVERFLOW, 32'h0);
        // The kept entry is the oldest; the overflowed one is lost
        pop(3, 3'h0);
        expCnt++;
        $display("overflow done");
        // Differential pair step then temperature step on sequencer two
        k = $urandom_range(3, 0);
        apb(1'b1, sa(2, SUB_MUX), 32'(k));
        apb(1'b1, sa(2, SUB_CTL), 32'he1);
        apb(1'b1, OFF_ENABLE, 32'h4);
        apb(1'b1, OFF_INITIATE, 32'h4);
        poll(OFF_RAW_IRQ, 32'h4, 32'h4);
        pop(2, 3'(2 * k));
        pop(2, 3'h7);
        apb(1'b1, OFF_IRQ_CLR, 32'h4);
        $display("differential done");
        // Loopback with averaging on the always trigger; converter unused
        apb(1'b1, OFF_AVERAGE, 32'h7);
        rchk("avgcap", OFF_AVERAGE, 32'h6);
        e = $urandom_range(6, 1);
        apb(1'b1, OFF_AVERAGE, 32'(e));
        apb(1'b1, OFF_LOOPBACK, 32'h1);
        apb(1'b1, sa(1, SUB_CTL), 32'h20);
        apb(1'b1, OFF_TRIG_SEL, {24'h0, TRIG_ALWAYS, 4'h0});
        apb(1'b1, OFF_ENABLE, 32'h2); // always trigger runs alone
        poll(OFF_OVERFLOW, 32'h2, 32'h2);
        chk("over1", 32'h2, rd & 32'h2);
        apb(1'b1, OFF_ENABLE, 32'h0);
        for (int j = 0; j < 4; j++) begin
            apb(1'b0, sa(1, SUB_FIFO), 32'h0);
            chk("loop", {27'h0, 2'd1, 3'(j % 2)}, rd);
        end
        $display("loopback done");
        final_report();
    end
endmodule
bind adc_seq_ctrl adc_seq_ctrl_sva SVA (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .trigEvents, .convStart, .convInput, .convDiff, .convTemp,
    .convDone, .convResult, .irqOut);
